// File: dv/adc_board_regs_chk.sv
`timescale 1ns/10ps
module adc_board_regs_chk
  import adc_regs_pkg::*;
#(
  parameter int INIT_CYCLES = 8
) (
  input wire logic              i_mclk,
  input wire logic              i_rst_b,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic              i_rd,
  input wire logic              i_wr,
  input wire logic [31:0]       i_wdata,
  input wire logic [31:0]       o_rdata,
  input wire logic              o_ack,
  input wire logic              o_convert,
  input wire logic [5:0]        o_chan_mask,
  input wire logic              o_cal_start,
  input wire logic [1:0]        o_input_mode,
  input wire logic              o_high_range,
  input wire logic              o_filter,
  input wire logic [7:0]        o_dio_oe
);
  int   cnt_q;
  int   cnt_d;
  logic idle;
  logic bcr_wr;
  logic cfg_wr;
  ////////////////////////////////////////////////////////////////////////////
  // init window, padded by two: a late guess only skips checks, never fires
  assign bcr_wr = i_wr && i_addr == BOARD_CTRL_OFS;
  assign cfg_wr = idle && i_wr && i_addr == IN_SETUP_OFS;
  assign idle = (cnt_q == 0);
  always_comb begin
    cnt_d = (cnt_q > 0) ? cnt_q - 1 : 0;
    if (idle && bcr_wr && i_wdata[INIT_BIT]) cnt_d = INIT_CYCLES + 2;
  end
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) cnt_q <= INIT_CYCLES + 2;
    else cnt_q <= cnt_d;
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);
  sequence s_bcr(b);
    idle && bcr_wr && !i_wdata[INIT_BIT] && i_wdata[b];
  endsequence
  sequence s_port_wr;
    idle && i_wr && i_addr == DIG_PORT_OFS;
  endsequence
  a_ack_after_access: assert property ((i_rd || i_wr) |=> o_ack)
    else $error("no ack after access");
  a_no_stray_ack: assert property (!(i_rd || i_wr) |=> !o_ack)
    else $error("ack without access");
  a_swclk_convert: assert property (s_bcr(SW_CLK_BIT) |-> ##[1:2] o_convert)
    else $error("software clock gave no convert");
  a_cal_launch: assert property (s_bcr(AUTOCAL_BIT) |=> o_cal_start)
    else $error("calibration not started");
  a_mask_update: assert property (cfg_wr |=> o_chan_mask == $past(i_wdata[5:0]))
    else $error("channel mask not updated");
  a_mode_update: assert property (cfg_wr |=> o_input_mode == $past(i_wdata[17:16])
    && o_high_range == $past(i_wdata[20]) && o_filter == $past(i_wdata[24]))
    else $error("input setup outputs wrong");
  a_dir_update: assert property (s_port_wr |=> o_dio_oe ==
    {{4{$past(i_wdata[15])}}, {4{$past(i_wdata[7])}}})
    else $error("port direction wrong");
  a_init_default: assert property (idle && bcr_wr && i_wdata[INIT_BIT] |=>
    o_chan_mask == 6'h3F && o_high_range && o_dio_oe == 8'h00)
    else $error("init did not restore defaults");
  a_rsvd_zero: assert property (i_rd && !i_wr && (i_addr == 8'h08 || i_addr == 8'h0C)
    |=> o_rdata == 32'h0)
    else $error("reserved register not zero");
endmodule // adc_board_regs_chk

bind adc_board_regs adc_board_regs_chk #(.INIT_CYCLES(INIT_CYCLES)) u_chk (.i_mclk, .i_rst_b,
  .i_addr, .i_rd, .i_wr, .i_wdata, .o_rdata, .o_ack, .o_convert, .o_chan_mask, .o_cal_start,
  .o_input_mode, .o_high_range, .o_filter, .o_dio_oe);

// File: dv/adc_board_regs_tb.sv
`timescale 1ns/10ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_total++; \
  $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end
module adc_board_regs_tb;
  import adc_regs_pkg::*;
  logic        i_mclk = 0, i_rst_b = 0, i_rd = 0, i_wr = 0, cal_ok = 0;
  logic [7:0]  i_addr = 0, ext = 0;
  logic [31:0] i_wdata = 0, o_rdata, x = 32'hAE159202;
  logic        o_ack, o_convert, o_adc_ready, o_cal_start, o_high_range, o_filter, o_warp;
  logic        adc_valid, cal_done;
  logic [17:0] adc_data;
  logic [2:0]  adc_chan;
  logic [5:0]  o_chan_mask;
  logic [1:0]  o_input_mode;
  logic [10:0] o_side_sync;
  logic [15:0] o_cal_value;
  logic [7:0]  o_dio, o_dio_oe;
  wire  logic [7:0] i_dio = (o_dio_oe & o_dio) | (~o_dio_oe & ext);
  int err_total = 0, checks_done = 0, cyc = 0, gap = 0, lc = 0;
  int exp_q[$];
  logic [7:0]  ra[12] = '{0, 8, 12, 16, 20, 28, 32, 36, 40, 44, 48, 60};
  logic [31:0] rv[12] = '{32'h220000, 0, 0, 0, 32'h10003F, 32'h1C2, 32'h2BF2, 32'h400, 0,
                          32'h3FFFE, 0, 0};
  adc_board_regs #(.INIT_CYCLES(8)) dut (.i_mclk, .i_rst_b, .i_addr, .i_rd, .i_wr, .i_wdata,
    .o_rdata, .o_ack, .i_ext_clk(1'b0), .i_ext_trig(1'b0), .o_convert, .o_chan_mask,
    .i_adc_valid(adc_valid), .i_adc_data(adc_data), .i_adc_chan(adc_chan), .o_adc_ready,
    .o_cal_start, .i_cal_done(cal_done), .i_cal_ok(cal_ok), .o_input_mode, .o_high_range,
    .o_filter, .o_warp, .o_side_sync, .o_cal_value, .i_dio, .o_dio, .o_dio_oe);
  adc_conv_model part (.i_mclk, .i_convert(o_convert), .i_mask(o_chan_mask),
    .i_ready(o_adc_ready), .i_cal_start(o_cal_start), .o_valid(adc_valid),
    .o_data(adc_data), .o_chan(adc_chan), .o_cal_done(cal_done));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge i_mclk);
    i_addr = a;
    i_wdata = d;
    i_wr = 1;
    @(negedge i_mclk);
    i_wr = 0;
  endtask
  task automatic chk(input logic [7:0] a, input logic [31:0] e);
    @(negedge i_mclk);
    i_addr = a;
    i_rd = 1;
    @(negedge i_mclk);
    i_rd = 0;
    // read data stands only in the cycle after the strobe
    `CHK(o_rdata, e)
  endtask
  // one software clock, then with buffer enable (bit 12) set the model's words become expectations
  task automatic conv(input logic [31:0] c);
    int w;
    wr(8'h00, c | 32'h100);
    repeat (20) @(negedge i_mclk);
    while (part.got.size() > 0) begin
      w = part.got.pop_front();
      if (c[12]) exp_q.push_back(((w >> 18) << 20) | ((w ^ (c[17] ? 32'h20000 : 0)) & 32'h3FFFF));
    end
  endtask
  task automatic drain();
    while (exp_q.size() > 0) chk(8'h18, exp_q.pop_front());
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #10 i_mclk = ~i_mclk;
  end
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      stop_test();
    end
  end
  always @(negedge i_mclk) if (o_convert) begin gap = cyc - lc; lc = cyc; end
  initial begin
    repeat (3) @(negedge i_mclk);
    i_rst_b = 1;
    repeat (12) @(negedge i_mclk);
    foreach (ra[i]) chk(ra[i], rv[i]);
    wr(8'h14, 32'hFFFFFFFF);
    chk(8'h14, IN_SETUP_MASK);
    wr(8'h10, 32'hFFFFFFFF);
    chk(8'h10, {21'h0, SIDE_SYNC_MASK});
    `CHK(o_side_sync, SIDE_SYNC_MASK)
    wr(8'h2C, 32'h2);
    conv(32'h21000);
    chk(8'h28, 32'h6);
    chk(8'h2C, 32'h100002);
    chk(8'h00, 32'h225000);
    drain();
    chk(8'h18, 32'h0);
    chk(8'h00, 32'h231000);
    wr(8'h00, 32'h1000);
    chk(8'h00, 32'h201000);
    x = xs(x);
    wr(8'h14, {26'h0, x[5:0] | 6'h1});
    conv(32'h1000);
    `CHK(exp_q.size(), $countones(x[5:0] | 6'h1))
    drain();
    wr(8'h1C, 32'h8);
    wr(8'h00, 32'h40000);
    repeat (40) @(negedge i_mclk);
    `CHK(gap, 8)
    wr(8'h30, 32'h40);
    conv(32'h0);
    chk(8'h28, 32'h0);
    chk(8'h30, 32'h400040);
    wr(8'h00, 32'h100000);
    chk(8'h00, 32'h300000);
    repeat (10) @(negedge i_mclk);
    chk(8'h00, 32'h0);
    x = xs(x);
    ext = x[7:0];
    wr(8'h04, 32'h8F);
    `CHK(o_dio_oe, 8'h0F)
    // pins pass two synchroniser stages before a read can see them
    repeat (2) @(negedge i_mclk);
    chk(8'h04, {16'h0, 4'h0, ext[7:4], 4'h8, 4'hF});
    wr(8'h00, 32'h80000000);
    chk(8'h00, 32'h80220000);
    repeat (12) @(negedge i_mclk);
    chk(8'h14, 32'h10003F);
    `CHK(o_dio_oe, 8'h00)
    stop_test();
  end
endmodule // adc_board_regs_tb

// File: dv/adc_conv_model.sv
`timescale 1ns/10ps
module adc_conv_model (
  input  wire logic        i_mclk,
  input  wire logic        i_convert,
  input  wire logic [5:0]  i_mask,
  input  wire logic        i_ready,
  input  wire logic        i_cal_start,
  output logic             o_valid = 1'b0,
  output logic      [17:0] o_data = 18'h0,
  output logic      [2:0]  o_chan = 3'h0,
  output logic             o_cal_done = 1'b0
);
  int   pend[$];
  int   got[$];
  int   seq = 0;
  int   cal_wait = 0;
  logic rdy = 1'b0;
  // ready is kept from the previous falling edge: that is what the design saw
  always @(negedge i_mclk) begin
    if (o_valid && rdy) begin
      got.push_back({o_chan, o_data});
      o_valid = 1'b0;
      o_data = ~o_data;
    end
    for (int c = 0; c < 6; c++) begin
      if (i_convert && i_mask[c]) pend.push_back(c);
    end
    if (!o_valid && pend.size() > 0) begin
      o_chan = 3'(pend.pop_front());
      o_data = 18'(seq * 40503);
      o_valid = 1'b1;
      seq++;
    end
    if (i_cal_start) cal_wait = 6;
    else if (cal_wait > 0) cal_wait--;
    o_cal_done = (cal_wait == 1);
    rdy = i_ready;
  end
endmodule // adc_conv_model

// File: hw/adc_board_regs.sv
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
module adc_rate_gen
  import adc_regs_pkg::*;
(
  input  wire logic        i_mclk,
  input  wire logic        i_rst_b,
  input  wire logic        i_en,
  input  wire logic [23:0] i_div,
  output logic             o_tick
);
  logic [23:0] cnt_q;
  logic [23:0] cnt_d;
  logic        tick_d;

  always_comb begin
    cnt_d  = 24'h000000;
    tick_d = 1'b0;
    if (i_en && (i_div != 24'h000000)) begin
      if (cnt_q >= i_div - 24'h000001) begin
        tick_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 24'h000001;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_q  <= 24'h000000;
      o_tick <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      o_tick <= tick_d;
    end
  end
endmodule // adc_rate_gen

////////////////////////////////////////////////////////////////////////////////
module adc_board_regs
  import adc_regs_pkg::*;
#(
  parameter int          INIT_CYCLES = LOGIC_INIT_CYCLES,
  parameter logic [11:0] FW_REVISION = 12'h001 // arbitrary value
) (
  input  wire logic              i_mclk,
  input  wire logic              i_rst_b,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic              i_rd,
  input  wire logic              i_wr,
  input  wire logic [31:0]       i_wdata,
  output logic      [31:0]       o_rdata,
  output logic                   o_ack,
  input  wire logic              i_ext_clk,
  input  wire logic              i_ext_trig,
  output logic                   o_convert,
  output logic      [5:0]        o_chan_mask,
  input  wire logic              i_adc_valid,
  input  wire logic [SAMPLE_W-1:0] i_adc_data,
  input  wire logic [2:0]        i_adc_chan,
  output logic                   o_adc_ready,
  output logic                   o_cal_start,
  input  wire logic              i_cal_done,
  input  wire logic              i_cal_ok,
  output logic      [1:0]        o_input_mode,
  output logic                   o_high_range,
  output logic                   o_filter,
  output logic                   o_warp,
  output logic      [10:0]       o_side_sync,
  output logic      [15:0]       o_cal_value,
  input  wire logic [7:0]        i_dio,
  output logic      [7:0]        o_dio,
  output logic      [7:0]        o_dio_oe
);
  // register state
  logic        burst_en_q, burst_en_d, buf_en_q, buf_en_d, ovf_q, ovf_d, unf_q, unf_d;
  logic        fmt_q, fmt_d, ra_en_q, ra_en_d, rb_en_q, rb_en_d, warp_q, warp_d;
  logic        diag_q, diag_d, cal_busy_q, cal_busy_d, cal_pass_q, cal_pass_d;
  logic        init_busy_q, init_busy_d, cal_start_q, cal_start_d, conv_q, conv_d;
  logic [31:0] init_cnt_q, init_cnt_d;
  logic [31:0] setup_q, setup_d;
  logic [23:0] rate_a_q, rate_a_d, rate_b_q, rate_b_d, burst_len_q, burst_len_d;
  logic [23:0] burst_cnt_q, burst_cnt_d;
  logic [18:0] level_lim_q, level_lim_d;
  logic [10:0] side_q, side_d;
  logic [15:0] cal_val_q, cal_val_d;
  logic [7:0]  dout_q, dout_d, sel_q, sel_d, resp_q, resp_d;
  logic        dir_lo_q, dir_lo_d, dir_hi_q, dir_hi_d;
  logic        thr_q, thr_d, thr_prev_q;
  logic [31:0] rdata_d;
  burst_state_t burst_q, burst_d;
  // fifo and buffer state
  logic [WORD_W-1:0] mem [0:(1<<FIFO_AW)-1];
  logic [FIFO_AW-1:0] wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
  logic [18:0]        fill_q, fill_d;
  logic [WORD_W-1:0]  skid0_q, skid0_d, skid1_q, skid1_d;
  logic [1:0]         skid_n_q, skid_n_d;
  // pins: ext clock, ext trigger, digital port
  logic [9:0] meta_q, sync_q, prev_q;
  logic       tick_a, tick_b;
  // combinational helpers
  logic wr_ok, init_go, clr_go, sw_clk, sw_trig, clk_ev, trig_ev, burst_start, burst_end;
  logic push, drain, pop, fifo_wr, over_ev, under_ev, last_sample_marker, cal_done_ev;
  logic [SAMPLE_W-1:0] sample_fmt;
  logic [7:0] events;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta_q <= 10'h000;
      sync_q <= 10'h000;
      prev_q <= 10'h000;
    end else begin
      meta_q <= {i_dio, i_ext_trig, i_ext_clk};
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  adc_rate_gen u_rate_a (
    .i_mclk (i_mclk),
    .i_rst_b(i_rst_b),
    .i_en   (ra_en_q),
    .i_div  (rate_a_q),
    .o_tick (tick_a)
  );

  adc_rate_gen u_rate_b (
    .i_mclk (i_mclk),
    .i_rst_b(i_rst_b),
    .i_en   (rb_en_q),
    .i_div  (rate_b_q),
    .o_tick (tick_b)
  );

  ////////////////////////////////////////////////////////////////////////////
  // sources, burst sequencing, sample path
  always_comb begin
    wr_ok   = i_wr && !init_busy_q;
    init_go = wr_ok && (i_addr == BOARD_CTRL_OFS) && i_wdata[INIT_BIT];
    clr_go  = wr_ok && (i_addr == BOARD_CTRL_OFS) && i_wdata[BUF_CLR_BIT];
    sw_clk  = wr_ok && (i_addr == BOARD_CTRL_OFS) && i_wdata[SW_CLK_BIT];
    sw_trig = wr_ok && (i_addr == BOARD_CTRL_OFS) && i_wdata[SW_TRIG_BIT];
    unique case (setup_q[9:8])
      SRC_RATE_A:   clk_ev = tick_a;
      SRC_RATE_B:   clk_ev = tick_b;
      SRC_EXTERNAL: clk_ev = sync_q[0] && !prev_q[0];
      default:      clk_ev = 1'b0;
    endcase
    unique case (setup_q[13:12])
      SRC_RATE_A:   trig_ev = tick_b;
      SRC_RATE_B:   trig_ev = tick_a;
      SRC_EXTERNAL: trig_ev = sync_q[1] && !prev_q[1];
      default:      trig_ev = 1'b0;
    endcase
    // a burst only starts from an idle, enabled sequencer
    burst_start = burst_en_q && (burst_q == BURST_IDLE) && (trig_ev || sw_trig);
    // software clock bypasses both the source and the burst gate
    conv_d = !init_busy_q && (sw_clk
             || (clk_ev && (!burst_en_q || burst_q == BURST_RUN)));
    // converter delivers two's complement; flip msb for offset binary
    sample_fmt = {i_adc_data[SAMPLE_W-1] ^ fmt_q, i_adc_data[SAMPLE_W-2:0]};
    push = i_adc_valid && o_adc_ready && buf_en_q && !clr_go;
    last_sample_marker  = (burst_q == BURST_RUN) && (burst_len_q != 24'h000000)
           && (burst_cnt_q == burst_len_q - 24'h000001);
    burst_end = (burst_q == BURST_RUN) && ((push && last_sample_marker) || !burst_en_q);
    burst_d = burst_q;
    burst_cnt_d = burst_cnt_q;
    if (burst_start) begin
      burst_d = BURST_RUN;
      burst_cnt_d = 24'h000000;
    end else if (burst_end) begin
      burst_d = BURST_IDLE;
    end else if (push && burst_q == BURST_RUN) begin
      burst_cnt_d = burst_cnt_q + 24'h000001;
    end
    // stall draining during initialisation so the buffer cannot fill
    drain = (skid_n_q != 2'h0) && !init_busy_q;
    fifo_wr = drain && (fill_q != FIFO_DEPTH) && !clr_go;
    over_ev = drain && (fill_q == FIFO_DEPTH);
    pop = i_rd && (i_addr == FIFO_READ_OFS) && (fill_q != 19'h00000);
    under_ev = i_rd && (i_addr == FIFO_READ_OFS) && (fill_q == 19'h00000);
    skid_n_d = skid_n_q;
    skid0_d = skid0_q;
    skid1_d = skid1_q;
    if (drain) begin
      skid0_d = skid1_q;
      skid_n_d = skid_n_d - 2'h1;
    end
    if (push) begin
      if (skid_n_d == 2'h0) begin
        skid0_d = {i_adc_chan, 1'b0, last_sample_marker, sample_fmt};
      end else begin
        skid1_d = {i_adc_chan, 1'b0, last_sample_marker, sample_fmt};
      end
      skid_n_d = skid_n_d + 2'h1;
    end
    wr_ptr_d = fifo_wr ? wr_ptr_q + 18'h00001 : wr_ptr_q;
    rd_ptr_d = pop ? rd_ptr_q + 18'h00001 : rd_ptr_q;
    fill_d = fill_q + {18'h00000, fifo_wr} - {18'h00000, pop};
    if (clr_go || init_go) begin
      skid_n_d = 2'h0;
      wr_ptr_d = '0;
      rd_ptr_d = '0;
      fill_d = 19'h00000;
      burst_d = BURST_IDLE;
    end
    thr_d = fill_q > level_lim_q;
  end

  always_ff @(posedge i_mclk) begin
    if (fifo_wr) begin
      mem[wr_ptr_q] <= skid0_q;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      burst_q     <= BURST_IDLE;
      burst_cnt_q <= 24'h000000;
      skid_n_q    <= 2'h0;
      skid0_q     <= '0;
      skid1_q     <= '0;
      wr_ptr_q    <= '0;
      rd_ptr_q    <= '0;
      fill_q      <= 19'h00000;
      thr_q       <= 1'b0;
      thr_prev_q  <= 1'b0;
      conv_q      <= 1'b0;
    end else begin
      burst_q     <= burst_d;
      burst_cnt_q <= burst_cnt_d;
      skid_n_q    <= skid_n_d;
      skid0_q     <= skid0_d;
      skid1_q     <= skid1_d;
      wr_ptr_q    <= wr_ptr_d;
      rd_ptr_q    <= rd_ptr_d;
      fill_q      <= fill_d;
      thr_q       <= thr_d;
      thr_prev_q  <= thr_q;
      conv_q      <= conv_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register file
  always_comb begin
    cal_done_ev = cal_busy_q && i_cal_done;
    events = {sync_q[2] && !prev_q[2], conv_q, burst_end, burst_start,
              over_ev || under_ev, thr_q && !thr_prev_q, !thr_q && thr_prev_q,
              cal_done_ev};
    {burst_en_d, buf_en_d, ovf_d, unf_d, fmt_d} = {burst_en_q, buf_en_q, ovf_q, unf_q, fmt_q};
    {ra_en_d, rb_en_d, warp_d, diag_d} = {ra_en_q, rb_en_q, warp_q, diag_q};
    {cal_busy_d, cal_pass_d} = {cal_busy_q, cal_pass_q};
    {setup_d, rate_a_d, rate_b_d, burst_len_d} = {setup_q, rate_a_q, rate_b_q, burst_len_q};
    {level_lim_d, side_d, cal_val_d} = {level_lim_q, side_q, cal_val_q};
    {dout_d, dir_lo_d, dir_hi_d, sel_d, resp_d} = {dout_q, dir_lo_q, dir_hi_q, sel_q, resp_q};
    cal_start_d = 1'b0;
    init_busy_d = init_busy_q;
    init_cnt_d = init_cnt_q;
    if (init_busy_q) begin
      if (init_cnt_q == 32'h00000000) begin
        init_busy_d = 1'b0;
      end else begin
        init_cnt_d = init_cnt_q - 32'h00000001;
      end
    end
    if (wr_ok) begin
      unique case (i_addr)
        BOARD_CTRL_OFS: begin
          burst_en_d = i_wdata[BURST_EN_BIT];
          buf_en_d = i_wdata[BUF_EN_BIT];
          ovf_d = ovf_q && i_wdata[OVF_BIT];
          unf_d = unf_q && i_wdata[UNF_BIT];
          fmt_d = i_wdata[FMT_BIT];
          ra_en_d = i_wdata[RATE_A_EN_BIT];
          rb_en_d = i_wdata[RATE_B_EN_BIT];
          warp_d = i_wdata[WARP_BIT];
          diag_d = i_wdata[DIAG_BIT];
          if (i_wdata[AUTOCAL_BIT] && !cal_busy_q) begin
            cal_busy_d = 1'b1;
            cal_pass_d = 1'b1;
            cal_start_d = 1'b1;
          end
        end
        DIG_PORT_OFS: begin
          dout_d = {i_wdata[11:8], i_wdata[3:0]};
          dir_lo_d = i_wdata[7];
          dir_hi_d = i_wdata[15];
        end
        SIDE_SYNC_OFS:  side_d = i_wdata[10:0] & SIDE_SYNC_MASK;
        IN_SETUP_OFS:   setup_d = i_wdata & IN_SETUP_MASK;
        RATE_A_OFS:     rate_a_d = i_wdata[23:0];
        RATE_B_OFS:     rate_b_d = i_wdata[23:0];
        BURST_LEN_OFS:  burst_len_d = i_wdata[23:0];
        LEVEL_LIM_OFS:  level_lim_d = i_wdata[18:0];
        EVENT_STAT_OFS: begin
          sel_d = i_wdata[7:0];
          resp_d = resp_q & i_wdata[23:16];
        end
        CAL_READ_OFS:   cal_val_d = i_wdata[15:0];
        default:        ;
      endcase
    end
    if (cal_done_ev) begin
      cal_busy_d = 1'b0;
      cal_pass_d = i_cal_ok;
    end
    // hardware sets land after the software clear so a same-cycle event wins
    if (over_ev) ovf_d = 1'b1;
    if (under_ev) unf_d = 1'b1;
    resp_d = resp_d | (sel_q & events);
    if (init_go) begin
      {burst_en_d, buf_en_d, ovf_d, unf_d, fmt_d} = 5'b00001;
      {ra_en_d, rb_en_d, warp_d, diag_d, cal_busy_d, cal_pass_d} = 6'b000001;
      {setup_d, rate_a_d, rate_b_d} = {IN_SETUP_RST, RATE_A_RST, RATE_B_RST};
      {burst_len_d, level_lim_d} = {BURST_LEN_RST, LEVEL_LIM_RST};
      {side_d, cal_val_d, sel_d, resp_d} = '0;
      {dout_d, dir_lo_d, dir_hi_d} = '0;
      init_busy_d = 1'b1;
      init_cnt_d = 32'(INIT_CYCLES - 1);
    end
    rdata_d = 32'h00000000;
    if (i_rd) begin
      unique case (i_addr)
        BOARD_CTRL_OFS: rdata_d = {init_busy_q, 7'h00, diag_q, warp_q, cal_pass_q,
                                   cal_busy_q, rb_en_q, ra_en_q, fmt_q, unf_q, ovf_q,
                                   thr_q, 1'b0, buf_en_q, 1'b0, burst_q == BURST_RUN,
                                   burst_en_q, 9'h000};
        DIG_PORT_OFS:   rdata_d = {16'h0000, dir_hi_q, 3'h0, sync_q[9:6],
                                   dir_lo_q, 3'h0, sync_q[5:2]};
        SIDE_SYNC_OFS:  rdata_d = {21'h000000, side_q};
        IN_SETUP_OFS:   rdata_d = setup_q;
        FIFO_READ_OFS:  rdata_d = pop ? {9'h000, mem[rd_ptr_q]} : 32'h00000000;
        RATE_A_OFS:     rdata_d = {8'h00, rate_a_q};
        RATE_B_OFS:     rdata_d = {8'h00, rate_b_q};
        BURST_LEN_OFS:  rdata_d = {8'h00, burst_len_q};
        FILL_CNT_OFS:   rdata_d = {13'h0000, fill_q};
        LEVEL_LIM_OFS:  rdata_d = {11'h000, thr_q, 1'b0, level_lim_q};
        EVENT_STAT_OFS: rdata_d = {8'h00, resp_q, 8'h00, sel_q};
        BUILD_OPT_OFS:  rdata_d = {14'h0000, 2'h2, 4'h0, FW_REVISION};
        CAL_READ_OFS:   rdata_d = {16'h0000, cal_val_q};
        default:        rdata_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      {burst_en_q, buf_en_q, ovf_q, unf_q, fmt_q} <= 5'b00001;
      {ra_en_q, rb_en_q, warp_q, diag_q, cal_busy_q, cal_pass_q} <= 6'b000001;
      setup_q     <= IN_SETUP_RST;
      rate_a_q    <= RATE_A_RST;
      rate_b_q    <= RATE_B_RST;
      burst_len_q <= BURST_LEN_RST;
      level_lim_q <= LEVEL_LIM_RST;
      side_q      <= 11'h000;
      cal_val_q   <= 16'h0000;
      dout_q      <= 8'h00;
      dir_lo_q    <= 1'b0;
      dir_hi_q    <= 1'b0;
      sel_q       <= 8'h00;
      resp_q      <= 8'h00;
      cal_start_q <= 1'b0;
      init_busy_q <= 1'b1;
      init_cnt_q  <= 32'(INIT_CYCLES - 1);
      o_rdata     <= 32'h00000000;
      o_ack       <= 1'b0;
    end else begin
      {burst_en_q, buf_en_q, ovf_q, unf_q, fmt_q} <= {burst_en_d, buf_en_d, ovf_d, unf_d, fmt_d};
      {ra_en_q, rb_en_q, warp_q, diag_q} <= {ra_en_d, rb_en_d, warp_d, diag_d};
      {cal_busy_q, cal_pass_q} <= {cal_busy_d, cal_pass_d};
      setup_q     <= setup_d;
      rate_a_q    <= rate_a_d;
      rate_b_q    <= rate_b_d;
      burst_len_q <= burst_len_d;
      level_lim_q <= level_lim_d;
      side_q      <= side_d;
      cal_val_q   <= cal_val_d;
      dout_q      <= dout_d;
      dir_lo_q    <= dir_lo_d;
      dir_hi_q    <= dir_hi_d;
      sel_q       <= sel_d;
      resp_q      <= resp_d;
      cal_start_q <= cal_start_d;
      init_busy_q <= init_busy_d;
      init_cnt_q  <= init_cnt_d;
      o_rdata     <= rdata_d;
      o_ack       <= i_rd || i_wr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign o_convert    = conv_q;
  assign o_chan_mask  = setup_q[5:0];
  assign o_adc_ready  = (skid_n_q != 2'h2);
  assign o_cal_start  = cal_start_q;
  assign o_input_mode = setup_q[17:16];
  assign o_high_range = setup_q[20];
  assign o_filter     = setup_q[24];
  assign o_warp       = warp_q;
  assign o_side_sync  = side_q;
  assign o_cal_value  = cal_val_q;
  assign o_dio        = dout_q;
  assign o_dio_oe     = {{4{dir_hi_q}}, {4{dir_lo_q}}};
endmodule // adc_board_regs

// File: include/adc_regs_pkg.sv
// Contract
// - software clock bit takes one sample of enabled channels, then clears itself.
// - bursts run only with burst enable high; busy bit reads high during burst.
// - software trigger bit starts one burst regardless of trigger source, self-clearing.
// - buffer accepts samples only when enabled; clear bit empties it and self-clears.
// - overflow and underflow flags stick until software writes them low or reset.
// - format bit high gives offset binary (reset value), low gives two's complement.
// - each rate generator runs only while its enable bit is high.
// - rate generator output rate is master clock divided by its 24-bit divider.
// - autocal bit launches calibration and clears itself on completion.
// - calibration pass forced high at reset and start; stays high only on success.
// - board_init_strobe bit restores all defaults, reads high during sequence, then clears.
// - start-up finishes within 3 ms, 300 ms and 1 ms budgets.
// - six channel mask bits, high enables channel, all enabled after reset.
// - clock source 0 rate A, 1 rate B, 2 external clock, 3 reserved.
// - trigger source 0 rate B, 1 rate A, 2 external trigger, 3 reserved.
// - input mode 0 system inputs, 2 zero selftest, 3 positive reference selftest.
// - range bit high selects high range (reset); filter bit high inserts filter.
// - buffer word holds 18-bit sample, end-of-burst marker, 3-bit channel, rest zero.
// - threshold flag high when fill exceeds 19-bit threshold; readable in two registers.
// - each digital port nibble drives its pins only while its direction bit is high.
// - eight selection bits enable response bits sixteen higher; edge responses stick.
package adc_regs_pkg;
  localparam int          ADDR_W         = 8;
  localparam logic [7:0]  BOARD_CTRL_OFS = 8'h00;
  localparam logic [7:0]  DIG_PORT_OFS   = 8'h04;
  localparam logic [7:0]  SIDE_SYNC_OFS  = 8'h10;
  localparam logic [7:0]  IN_SETUP_OFS   = 8'h14;
  localparam logic [7:0]  FIFO_READ_OFS  = 8'h18;
  localparam logic [7:0]  RATE_A_OFS     = 8'h1C;
  localparam logic [7:0]  RATE_B_OFS     = 8'h20;
  localparam logic [7:0]  BURST_LEN_OFS  = 8'h24;
  localparam logic [7:0]  FILL_CNT_OFS   = 8'h28;
  localparam logic [7:0]  LEVEL_LIM_OFS  = 8'h2C;
  localparam logic [7:0]  EVENT_STAT_OFS = 8'h30;
  localparam logic [7:0]  BUILD_OPT_OFS  = 8'h34;
  localparam logic [7:0]  CAL_READ_OFS   = 8'h38;
  // board control bit positions, and the level register flag bit
  localparam int SW_CLK_BIT = 8;
  localparam int BURST_EN_BIT = 9;
  localparam int SW_TRIG_BIT = 11;
  localparam int BUF_EN_BIT = 12;
  localparam int BUF_CLR_BIT = 13;
  localparam int OVF_BIT = 15;
  localparam int UNF_BIT = 16;
  localparam int FMT_BIT = 17;
  localparam int RATE_A_EN_BIT = 18;
  localparam int RATE_B_EN_BIT = 19;
  localparam int AUTOCAL_BIT = 20;
  localparam int WARP_BIT = 22;
  localparam int DIAG_BIT = 23;
  localparam int INIT_BIT = 31;
  localparam int LEVEL_FLAG_BIT = 20;
  // reset values, write masks and source codes
  localparam logic [31:0] IN_SETUP_RST   = 32'h0010003F;
  localparam logic [31:0] IN_SETUP_MASK  = 32'h0113333F;
  localparam logic [23:0] RATE_A_RST     = 24'h0001C2;
  localparam logic [23:0] RATE_B_RST     = 24'h002BF2;
  localparam logic [23:0] BURST_LEN_RST  = 24'h000400;
  localparam logic [18:0] LEVEL_LIM_RST  = 19'h3FFFE;
  localparam logic [10:0] SIDE_SYNC_MASK = 11'h70F;
  localparam logic [1:0]  SRC_RATE_A     = 2'h0;
  localparam logic [1:0]  SRC_RATE_B     = 2'h1;
  localparam logic [1:0]  SRC_EXTERNAL   = 2'h2;
  // fifo geometry
  localparam int SAMPLE_W = 18;
  localparam int WORD_W = 23;
  localparam int FIFO_AW = 18;
  localparam logic [18:0] FIFO_DEPTH = 19'h40000;
  // timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int BUS_CFG_MAX_NS = 3_000_000;
  localparam int CTRL_CFG_MAX_NS = 300_000_000;
  localparam int LOGIC_INIT_MAX_NS = 1_000_000;
  localparam int LOGIC_INIT_CYCLES = LOGIC_INIT_MAX_NS / CLK_PERIOD_NS;
  typedef enum logic {BURST_IDLE, BURST_RUN} burst_state_t;
endpackage
